// ==== charge_supply_pkg.sv ====
// Purpose: Shared constants and types for the charge counter and supply average readout.
// Assumes: One 10 MHz clock; registers reached over an Avalon-MM slave with waitrequest.
// Notes: Byte address of a register is four times its index.

package charge_supply_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [5:0] IDX_CNT_HIGH = 6'h19;
  localparam logic [5:0] IDX_CNT_LOW = 6'h1A;
  localparam logic [5:0] IDX_AVG_HIGH = 6'h1B;
  localparam logic [5:0] IDX_AVG_LOW = 6'h1C;
  localparam logic [5:0] IDX_CTRL = 6'h20;
  localparam logic [5:0] IDX_STATUS = 6'h21;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned CODE_W = 12;
  localparam int unsigned FRAC_W = 8;
  localparam int unsigned PRESC_W = 6;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CAL_TIME_US = 1000;
  localparam int unsigned CAL_CYCLES_DEFAULT = (CAL_TIME_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
                                               CAL_TIME_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------
  // Types
  // ----------------------------------------
  // Control byte; bit 7 down to bit 0.
  typedef struct packed {
    logic secondary_supply_present_bit;
    logic [2:0] average_filter_time_constant;
    logic [1:0] counter_pulse_prescaler;
    logic counter_clear_event;
    logic cal_start;
  } ctrl_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN = 2'b01,
    CAL_HOLD = 2'b10
  } cal_state_t;

endpackage

// ==== pin_sync.sv ====
// Purpose: Bring an asynchronous pulse pin into the mclk domain and flag its rising edges.
// Assumes: Pin pulses are wider than three mclk periods.
// Notes: A change is accepted once the second and third stages agree.
`timescale 1ns/10ps
`default_nettype none

module pin_sync (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic pin,
  output logic rise
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.s1 = pin;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.rise = 1'b0;
    if (s_q.s2 == s_q.s3) begin
      s_d.level = s_q.s3;
      s_d.rise = s_q.s3 & ~s_q.level;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rise = s_q.rise;

endmodule
`default_nettype wire

// ==== iir_average.sv ====
// Purpose: First-order IIR low-pass of the selected supply code.
// Assumes: Samples arrive as one-cycle strobes on mclk.
// Notes: Eight fraction bits keep small steps from being lost at long time constants.
`timescale 1ns/10ps
`default_nettype none

module iir_average
  import charge_supply_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clear,
  input wire logic sample_valid,
  input wire logic [charge_supply_pkg::CODE_W-1:0] sample,
  input wire logic [2:0] tau,
  output logic [charge_supply_pkg::CODE_W-1:0] average
);

  typedef struct packed {
    logic [CODE_W+FRAC_W-1:0] acc;
    logic seeded;
  } iir_state_t;

  iir_state_t s_q;
  iir_state_t s_d;
  logic signed [CODE_W+FRAC_W:0] diff;
  logic signed [CODE_W+FRAC_W:0] sum;

  always_comb begin
    s_d = s_q;
    diff = $signed({1'b0, sample, {FRAC_W{1'b0}}}) - $signed({1'b0, s_q.acc});
    sum = $signed({1'b0, s_q.acc}) + (diff >>> tau);
    if (clear) begin
      s_d = '0;
    end else if (sample_valid) begin
      // The first sample after a clear seeds the filter so it does not ramp from zero.
      if (!s_q.seeded) begin
        s_d.acc = {sample, {FRAC_W{1'b0}}};
        s_d.seeded = 1'b1;
      end else begin
        s_d.acc = sum[CODE_W+FRAC_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign average = s_q.acc[CODE_W+FRAC_W-1:FRAC_W];

endmodule
`default_nettype wire

// ==== charge_supply_readout.sv ====
// Purpose: Third output charge counter and supply average readout behind an Avalon-MM slave.
// Assumes: Converter codes are already scaled per pin; the pulse pin is asynchronous.
// Notes: Every request takes one wait cycle; side effects happen once, at acceptance.
`timescale 1ns/10ps
`default_nettype none

module charge_supply_readout
  import charge_supply_pkg::*;
#(
  parameter int unsigned CAL_CYCLES = charge_supply_pkg::CAL_CYCLES_DEFAULT
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [charge_supply_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [charge_supply_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [charge_supply_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pfm_pulse_pin,
  input wire logic adc_sample_valid,
  input wire logic [charge_supply_pkg::CODE_W-1:0] primary_battery_code,
  input wire logic [charge_supply_pkg::CODE_W-1:0] secondary_supply_code,
  output logic measure_secondary,
  output logic cal_running
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic waitreq;
    logic [DATA_W-1:0] rdata;
    ctrl_t ctrl;
    logic [CNT_W-1:0] count;
    logic [PRESC_W-1:0] presc;
    cal_state_t cal;
    logic [31:0] cal_cnt;
    logic cal_running;
    logic [7:0] cnt_shadow;
    logic [7:0] avg_shadow;
    logic filter_clear;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic pulse_rise;
  logic [CODE_W-1:0] average;
  logic [CODE_W-1:0] selected_code;
  logic filter_valid;
  logic req;
  logic accept;
  logic [5:0] idx;
  logic addr_ok;
  logic cnt_addressed;
  logic avg_addressed;
  ctrl_t wr_ctrl;

  localparam logic [31:0] CAL_LAST = 32'(CAL_CYCLES - 1);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Group size is 1, 4, 16 or 64 pulses per count.
  function automatic logic [PRESC_W-1:0] group_last(input logic [1:0] sel);
    logic [PRESC_W-1:0] r;
    case (sel)
      2'b00: r = 6'h00;
      2'b01: r = 6'h03;
      2'b10: r = 6'h0F;
      2'b11: r = 6'h3F;
      default: r = 6'h00;
    endcase
    return r;
  endfunction

  function automatic logic is_index(input logic [ADDR_W-1:0] a, input logic [5:0] i);
    return (a[1:0] == 2'b00) && (a[7:2] == i);
  endfunction

  // ----------------------------------------
  // Inputs
  // ----------------------------------------
  pin_sync u_pulse_sync (
    .mclk(mclk),
    .arst_n(arst_n),
    .pin(pfm_pulse_pin),
    .rise(pulse_rise)
  );

  assign selected_code = s_q.ctrl.secondary_supply_present_bit ? secondary_supply_code :
                         primary_battery_code;

  assign req = avs_read | avs_write;
  assign accept = req & s_q.waitreq;
  assign idx = avs_address[7:2];
  assign addr_ok = (avs_address[1:0] == 2'b00);
  // Any cycle that the request sits on a two-part register drops pulse edges or converter samples for that value.
  assign cnt_addressed = req & (is_index(avs_address, IDX_CNT_HIGH) | is_index(avs_address, IDX_CNT_LOW));
  assign avg_addressed = req & (is_index(avs_address, IDX_AVG_HIGH) | is_index(avs_address, IDX_AVG_LOW));
  assign filter_valid = adc_sample_valid & ~avg_addressed;
  assign wr_ctrl = ctrl_t'(avs_writedata[7:0]);

  iir_average u_average (
    .mclk(mclk),
    .arst_n(arst_n),
    .clear(s_q.filter_clear),
    .sample_valid(filter_valid),
    .sample(selected_code),
    .tau(s_q.ctrl.average_filter_time_constant),
    .average(average)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ctrl.cal_start = 1'b0;
    s_d.ctrl.counter_clear_event = 1'b0;
    s_d.filter_clear = 1'b0;

    // One wait cycle, then the answer; back to waiting in the cycle after.
    s_d.waitreq = ~accept;

    // Counter and calibration sequence.
    if (s_q.ctrl.counter_clear_event) begin
      s_d.count = CNT_RESET;
      s_d.presc = '0;
      s_d.cal = CAL_IDLE;
      s_d.cal_running = 1'b0;
      s_d.filter_clear = 1'b1;
    end else begin
      case (s_q.cal)
        CAL_IDLE: begin
          if (s_q.ctrl.cal_start) begin
            // Calibration overwrites the charge count; the host must save it first.
            s_d.count = CNT_RESET;
            s_d.cal_cnt = 32'h0000_0000;
            s_d.cal = CAL_RUN;
            s_d.cal_running = 1'b1;
          end else if (pulse_rise && !cnt_addressed) begin
            // Pulses that land while the counter is addressed are lost, not queued.
            if (s_q.presc == group_last(s_q.ctrl.counter_pulse_prescaler)) begin
              s_d.presc = '0;
              s_d.count = s_q.count + 16'h0001;
            end else begin
              s_d.presc = s_q.presc + 6'h01;
            end
          end
        end
        CAL_RUN: begin
          // Each mclk cycle is one reference clock cycle; reads do not stop it.
          s_d.count = s_q.count + 16'h0001;
          s_d.cal_cnt = s_q.cal_cnt + 32'h0000_0001;
          if (s_q.cal_cnt == CAL_LAST) begin
            s_d.cal = CAL_HOLD;
            s_d.cal_running = 1'b0;
          end
        end
        CAL_HOLD: begin
          s_d.count = s_q.count;
        end
        default: begin
          s_d.cal = CAL_IDLE;
          s_d.cal_running = 1'b0;
        end
      endcase
    end

    // Register accesses, acted on once at acceptance.
    if (accept) begin
      s_d.rdata = '0;
      if (avs_read && addr_ok) begin
        case (idx)
          IDX_CNT_HIGH: begin
            s_d.rdata[7:0] = s_q.count[15:8];
            s_d.cnt_shadow = s_q.count[7:0];
          end
          IDX_CNT_LOW: begin
            s_d.rdata[7:0] = s_q.cnt_shadow;
          end
          IDX_AVG_HIGH: begin
            s_d.rdata[3:0] = average[11:8];
            s_d.avg_shadow = average[7:0];
          end
          IDX_AVG_LOW: begin
            s_d.rdata[7:0] = s_q.avg_shadow;
          end
          IDX_CTRL: begin
            s_d.rdata[7:0] = {s_q.ctrl[7:2], 2'b00};
          end
          IDX_STATUS: begin
            s_d.rdata[2:0] = {s_q.cal, s_q.cal_running};
          end
          default: begin
            s_d.rdata = '0;
          end
        endcase
      end
      // Writes to read-only or unmapped words are ignored.
      if (avs_write && avs_byteenable[0] && is_index(avs_address, IDX_CTRL)) begin
        s_d.ctrl = wr_ctrl;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.waitreq <= 1'b1;
      s_q.ctrl <= ctrl_t'(CTRL_RESET);
      s_q.cnt_shadow <= BYTE_RESET;
      s_q.avg_shadow <= BYTE_RESET;
      s_q.cal <= CAL_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.waitreq;
  assign measure_secondary = s_q.ctrl.secondary_supply_present_bit;
  assign cal_running = s_q.cal_running;

endmodule
`default_nettype wire

// ==== charge_supply_readout_assertions.sv ====
// Purpose: Port checks for the charge and supply readout block.
// Assumes: CAL_CYCLES equals the value of the bound instance.
// Notes: Sees only the ports of the top module.
`timescale 1ns/10ps
`default_nettype none
module charge_supply_readout_assertions #(
  parameter int unsigned CAL_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic measure_secondary,
  input wire logic cal_running
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic seen_q;
  logic [15:0] run_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      seen_q <= 1'b0;
      run_q <= 16'h0000;
    end else begin
      seen_q <= seen_q | avs_read;
      run_q <= cal_running ? run_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_ack;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  property p_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  property p_hold;
    $changed(avs_readdata) |-> !avs_waitrequest;
  endproperty
  property p_nib;
    avs_read && avs_waitrequest && avs_address == 8'h6C |=> avs_readdata[31:4] == 28'h0;
  endproperty
  property p_byte;
    avs_read && avs_waitrequest && avs_address inside {8'h64, 8'h68, 8'h70} |=> avs_readdata[31:8] == 24'h0;
  endproperty
  property p_sel;
    $changed(measure_secondary) |-> $past(avs_write);
  endproperty
  property p_cal;
    $fell(cal_running) |-> run_q == CAL_CYCLES[15:0];
  endproperty
  property p_rst;
    !seen_q |-> avs_readdata == 32'h0;
  endproperty
  a_ack: assert property (p_ack) else $error("request not answered");
  a_one: assert property (p_one) else $error("wait low too long");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_nib: assert property (p_nib) else $error("reserved bits set");
  a_byte: assert property (p_byte) else $error("byte too wide");
  a_sel: assert property (p_sel) else $error("pin select moved");
  a_cal: assert property (p_cal) else $error("calibration length");
  a_rst: assert property (p_rst) else $error("read data after reset");
  c_cal: cover property ($fell(cal_running));
  c_sec: cover property ($rose(measure_secondary));
  c_cnt: cover property (avs_read && avs_address == 8'h64);
endmodule
bind charge_supply_readout charge_supply_readout_assertions #(.CAL_CYCLES(CAL_CYCLES)) chk_u (
  .mclk(mclk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .measure_secondary(measure_secondary), .cal_running(cal_running));
`default_nettype wire

// ==== host_model.sv ====
// Purpose: Host side of the register bus.
// Assumes: One request at a time.
// Notes: Waits for the answer with no cycle count of its own.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic mclk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
  end
  // ----------------------------------------
  // Bus cycle
  // ----------------------------------------
  // Counters are addressed only inside a real request, and upper bits are written as zero.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    @(posedge mclk);
    while (avs_waitrequest) @(posedge mclk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== charge_supply_readout_test.sv ====
// Purpose: Self-checking bench of the charge and supply readout block.
// Assumes: Calibration shortened to 20 cycles.
// Notes: Bus traffic goes through the host model.
`timescale 1ns/10ps
`default_nettype none
module charge_supply_readout_test;
  import charge_supply_pkg::*;
  localparam int unsigned CAL_N = 20;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic pin = 1'b0;
  logic valid = 1'b0;
  logic [11:0] prim = 12'h0;
  logic [11:0] sec = 12'h0;
  logic [7:0] addr;
  logic rd, wr_en, wait_r, meas, calr;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  int error_cnt = 0;
  int tests_run = 0;
  always #50 mclk = ~mclk;
  host_model host_u (.mclk(mclk), .avs_waitrequest(wait_r), .avs_readdata(rdata), .avs_address(addr),
    .avs_read(rd), .avs_write(wr_en), .avs_writedata(wdata), .avs_byteenable(be));
  charge_supply_readout #(.CAL_CYCLES(CAL_N)) dut_u (.mclk(mclk), .arst_n(arst_n), .avs_address(addr),
    .avs_read(rd), .avs_write(wr_en), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wait_r), .pfm_pulse_pin(pin), .adc_sample_valid(valid), .primary_battery_code(prim),
    .secondary_supply_code(sec), .measure_secondary(meas), .cal_running(calr));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    host_u.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    host_u.xfer(1'b0, a, 8'h00, q);
    chk($sformatf("reg %0h", a), q, e);
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge mclk) pin <= 1'b1;
      repeat (4) @(posedge mclk);
      pin <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    repeat (8) @(posedge mclk);
  endtask
  task automatic samp(input logic [11:0] p, input logic [11:0] s);
    @(posedge mclk);
    prim <= p;
    sec <= s;
    valid <= 1'b1;
    @(posedge mclk) valid <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdc(8'h64, 32'h0);
    rdc(8'h68, 32'h0);
    rdc(8'h6C, 32'h0);
    rdc(8'h70, 32'h0);
    wr(8'h68, 8'h5A);
    rdc(8'h68, 32'h0);
    rdc(8'h7C, 32'h0);
    chk("cal_running", {31'h0, calr}, 32'h0);
  endtask
  task automatic t_count;
    pulses(5);
    rdc(8'h64, 32'h0);
    rdc(8'h68, 32'h05);
    wr(8'h80, 8'h06);
    pulses(8);
    rdc(8'h64, 32'h0);
    pulses(4);
    rdc(8'h68, 32'h02);
    rdc(8'h64, 32'h0);
    rdc(8'h68, 32'h03);
  endtask
  task automatic t_cal;
    rdc(8'h64, 32'h0);
    rdc(8'h68, 32'h03);
    wr(8'h80, 8'h01);
    repeat (5) @(posedge mclk);
    chk("cal_running", {31'h0, calr}, 32'h1);
    pulses(3);
    chk("cal_running", {31'h0, calr}, 32'h0);
    rdc(8'h84, 32'h04);
    rdc(8'h64, 32'h0);
    rdc(8'h68, CAL_N);
    wr(8'h80, 8'h02);
    rdc(8'h64, 32'h0);
    rdc(8'h68, 32'h0);
  endtask
  task automatic t_avg;
    samp(12'hABC, 12'h123);
    rdc(8'h6C, 32'h0A);
    rdc(8'h70, 32'hBC);
    wr(8'h80, 8'h80);
    chk("measure_secondary", {31'h0, meas}, 32'h1);
    samp(12'hABC, 12'h456);
    rdc(8'h6C, 32'h04);
    rdc(8'h70, 32'h56);
    wr(8'h80, 8'h12);
    chk("measure_secondary", {31'h0, meas}, 32'h0);
    samp(12'h100, 12'h0);
    samp(12'h200, 12'h0);
    rdc(8'h6C, 32'h01);
    rdc(8'h70, 32'h80);
  endtask
  // A pulse edge and a converter sample that land while their register is addressed are lost.
  task automatic t_inhibit;
    logic [31:0] q;
    fork
      begin
        @(posedge mclk) pin <= 1'b1;
        repeat (4) @(posedge mclk);
        pin <= 1'b0;
      end
      begin
        repeat (4) @(posedge mclk);
        host_u.xfer(1'b0, 8'h68, 8'h00, q);
      end
    join
    repeat (4) @(posedge mclk);
    pulses(1);
    rdc(8'h64, 32'h0);
    rdc(8'h68, 32'h01);
    fork
      host_u.xfer(1'b0, 8'h70, 8'h00, q);
      begin
        @(posedge mclk);
        prim <= 12'h300;
        valid <= 1'b1;
        @(posedge mclk) valid <= 1'b0;
      end
    join
    repeat (4) @(posedge mclk);
    rdc(8'h6C, 32'h01);
    rdc(8'h70, 32'h80);
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset;
    t_count;
    t_cal;
    t_avg;
    t_inhibit;
    stop_test;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    stop_test;
  end
endmodule
`default_nettype wire
